// *** pce_defines.svh ***
// constants of the programmable crc engine: reset values, field positions, offsets
// assumes inclusion by both ends and by the interface
`ifndef PCE_DEFINES_SVH
`define PCE_DEFINES_SVH
`define PCE_POLY_RESET 32'hEDB88320
`define PCE_VAL_RESET 32'h00000000
`define PCE_CTRL_RESET 5'h00
`define PCE_CTRL_W 5
`define PCE_CTRL_EN 0
`define PCE_CTRL_DMA 1
`define PCE_CTRL_MSB 2
`define PCE_CTRL_SWIN 3
`define PCE_CTRL_SWOUT 4
`define PCE_STAT_BUSY 16
`define PCE_ADDR_CTRL 2'h0
`define PCE_ADDR_DATA 2'h1
`define PCE_ADDR_POLY 2'h2
`define PCE_ADDR_VAL 2'h3
`define PCE_BE_BYTE 4'h1
`define PCE_BE_HALF 4'h3
`define PCE_BITS_BYTE 6'h08
`define PCE_BITS_HALF 6'h10
`define PCE_BITS_WORD 6'h20
`define PCE_CNT_LAST 6'h01
`endif

// *** pce_pkg.sv ***
// types and shared helpers of the programmable crc engine
// assumes nothing beyond the defines header
package pce_pkg;
	typedef enum logic [1:0] {PCE_SZ_8, PCE_SZ_16, PCE_SZ_32} pce_size_t;
	typedef enum logic [1:0] {PCE_SEL_CTRL, PCE_SEL_POLY, PCE_SEL_VAL} pce_sel_t;
	typedef enum {PCE_IDLE, PCE_SHIFT} pce_state_t;

	function automatic logic [31:0] pce_bswap(input logic [31:0] w);
		return {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction : pce_bswap

	function automatic logic [31:0] pce_bitrev(input logic [31:0] w);
		logic [31:0] r;
		r = 32'h00000000;
		for (int i = 0; i < 32; i++)
		begin
			r[i] = w[31 - i];
		end
		return r;
	endfunction : pce_bitrev
endpackage : pce_pkg

// *** pce_if.sv ***
// link between the bus-side controller and the crc engine
// assumes both ends share i_mclk; no signal crosses a clock domain
`timescale 1ns/10ps
`include "pce_defines.svh"
interface pce_if;
	import pce_pkg::*;
	logic cfg_wr;
	pce_sel_t cfg_sel;
	logic [31:0] cfg_wdata;
	logic dat_valid;
	logic dat_ready;
	pce_size_t dat_size;
	logic [31:0] dat_word;
	logic busy;
	logic dma_req;
	logic [`PCE_CTRL_W-1:0] ctrl_rd;
	logic [31:0] poly_rd;
	logic [31:0] val_rd;

	modport engine (
		input cfg_wr, cfg_sel, cfg_wdata, dat_valid, dat_size, dat_word,
		output dat_ready, busy, dma_req, ctrl_rd, poly_rd, val_rd
	);
	modport host (
		output cfg_wr, cfg_sel, cfg_wdata, dat_valid, dat_size, dat_word,
		input dat_ready, busy, dma_req, ctrl_rd, poly_rd, val_rd
	);
endinterface : pce_if

// *** pce_engine.sv ***
// programmable crc engine: control, polynomial and value state plus a bit-serial core
// assumes a single clock i_mclk and a partner that drives pce_if on that clock
//
// How it works
// - any 32-bit stored polynomial up to order 32
// - words of 8, 16 or 32 bits accepted
// - busy high while computing, value then readable
// - writer counts data; engine knows no length
// - bit order select: 0 lsb first, 1 msb
// - top polynomial term implied, never stored
// - lsb mode wants bit-reversed polynomial from software
// - result reflected and/or byte swapped on readout
// - msb mode: polynomial left-justified, low bit set
// - msb mode: left-justify seed, right-shift short result
// - polynomial resets to reflected ethernet crc-32
// - polynomial changed only while not busy
// - separate byte swap of input and result
// - input swap 1: most significant byte first
// - enable and dma enable raise dma request
// - no data writes while busy or disabled; the host instead buffers up to two words and stalls further writes
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
`include "pce_defines.svh"
module pce_engine
	import pce_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_reset,
	pce_if.engine lnk,
	output logic o_busy,
	output logic [31:0] o_crc_value
);
	pce_state_t st_q;
	pce_state_t st_d;
	logic [5:0] cnt_q;
	logic [5:0] cnt_d;
	logic [31:0] sh_q;
	logic [31:0] sh_d;
	logic [31:0] crc_q;
	logic [31:0] crc_d;
	logic [31:0] poly_q;
	logic [31:0] poly_d;
	logic [`PCE_CTRL_W-1:0] ctrl_q;
	logic [`PCE_CTRL_W-1:0] ctrl_d;
	logic busy_q;
	logic busy_d;
	logic dma_q;
	logic dma_d;
	logic [31:0] rd_q;
	logic [31:0] rd_d;
	logic take;
	logic in_bit;

	// one lfsr step; the x^n term sits just outside the register, so it is implied
	function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic b,
		input logic [31:0] poly, input logic msb);
		logic fb;
		logic [31:0] nxt;
		fb = 1'b0;
		nxt = crc;
		if (msb)
		begin
			fb = crc[31] ^ b;
			nxt = {crc[30:0], 1'b0} ^ (fb ? poly : 32'h00000000);
		end
		else
		begin
			fb = crc[0] ^ b;
			nxt = {1'b0, crc[31:1]} ^ (fb ? poly : 32'h00000000);
		end
		return nxt;
	endfunction : crc_step

	// places the bytes in consumption order: first byte at the low end for lsb mode,
	// at the high end for msb mode, so the core always shifts from one fixed bit
	function automatic logic [31:0] stage_word(input logic [31:0] d, input pce_size_t sz,
		input logic swap, input logic msb);
		logic [31:0] w;
		w = d;
		case (sz)
			PCE_SZ_8: w = {24'h000000, d[7:0]};
			PCE_SZ_16: w = swap ? {16'h0000, d[7:0], d[15:8]} : {16'h0000, d[15:0]};
			PCE_SZ_32: w = swap ? pce_bswap(d) : d;
			default: w = d;
		endcase
		return msb ? pce_bswap(w) : w;
	endfunction : stage_word

	function automatic logic [5:0] size_bits(input pce_size_t sz);
		logic [5:0] n;
		case (sz)
			PCE_SZ_8: n = `PCE_BITS_BYTE;
			PCE_SZ_16: n = `PCE_BITS_HALF;
			default: n = `PCE_BITS_WORD;
		endcase
		return n;
	endfunction : size_bits

	// result view: reflect first, then byte swap
	function automatic logic [31:0] present(input logic [31:0] v, input logic msb,
		input logic swo);
		logic [31:0] r;
		r = msb ? pce_bitrev(v) : v;
		return swo ? pce_bswap(r) : r;
	endfunction : present

	// accepting only when enabled and idle keeps a word written too early waiting upstream
	assign take = lnk.dat_valid & lnk.dat_ready;
	assign in_bit = ctrl_q[`PCE_CTRL_MSB] ? sh_q[31] : sh_q[0];

	always_comb
	begin
		ctrl_d = ctrl_q;
		poly_d = poly_q;
		if (lnk.cfg_wr && lnk.cfg_sel == PCE_SEL_CTRL)
		begin
			ctrl_d = lnk.cfg_wdata[`PCE_CTRL_W-1:0];
		end
		// the partner only writes here while idle, so no step sees a half-changed polynomial
		if (lnk.cfg_wr && lnk.cfg_sel == PCE_SEL_POLY)
		begin
			poly_d = lnk.cfg_wdata;
		end
	end

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			ctrl_q <= `PCE_CTRL_RESET;
			poly_q <= `PCE_POLY_RESET;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			poly_q <= poly_d;
		end
	end

	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		crc_d = crc_q;
		if (lnk.cfg_wr && lnk.cfg_sel == PCE_SEL_VAL)
		begin
			crc_d = lnk.cfg_wdata;
		end
		case (st_q)
			PCE_IDLE:
			begin
				if (take)
				begin
					sh_d = stage_word(lnk.dat_word, lnk.dat_size, ctrl_q[`PCE_CTRL_SWIN],
						ctrl_q[`PCE_CTRL_MSB]);
					cnt_d = size_bits(lnk.dat_size);
					st_d = PCE_SHIFT;
				end
			end
			PCE_SHIFT:
			begin
				crc_d = crc_step(crc_q, in_bit, poly_q, ctrl_q[`PCE_CTRL_MSB]);
				sh_d = ctrl_q[`PCE_CTRL_MSB] ? {sh_q[30:0], 1'b0} : {1'b0, sh_q[31:1]};
				cnt_d = cnt_q - `PCE_CNT_LAST;
				if (cnt_q == `PCE_CNT_LAST)
				begin
					st_d = PCE_IDLE;
				end
			end
			default:
			begin
				st_d = PCE_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			st_q <= PCE_IDLE;
			cnt_q <= 6'h00;
			sh_q <= 32'h00000000;
			crc_q <= `PCE_VAL_RESET;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			crc_q <= crc_d;
		end
	end

	// status is computed from next values so busy falls together with the final value
	always_comb
	begin
		busy_d = (st_d == PCE_SHIFT);
		dma_d = ctrl_d[`PCE_CTRL_EN] & ctrl_d[`PCE_CTRL_DMA] & ~busy_d;
		rd_d = present(crc_d, ctrl_d[`PCE_CTRL_MSB], ctrl_d[`PCE_CTRL_SWOUT]);
	end

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			busy_q <= 1'b0;
			dma_q <= 1'b0;
			rd_q <= `PCE_VAL_RESET;
		end
		else
		begin
			busy_q <= busy_d;
			dma_q <= dma_d;
			rd_q <= rd_d;
		end
	end

	assign lnk.dat_ready = ctrl_q[`PCE_CTRL_EN] & (st_q == PCE_IDLE);
	assign lnk.busy = busy_q;
	assign lnk.dma_req = dma_q;
	assign lnk.ctrl_rd = ctrl_q;
	assign lnk.poly_rd = poly_q;
	assign lnk.val_rd = rd_q;
	assign o_busy = busy_q;
	assign o_crc_value = rd_q;
endmodule : pce_engine

// *** pce_host.sv ***
// bus-side controller: avalon-mm slave with waitrequest, a two-entry data buffer,
// and the driver of pce_if toward the crc engine
// assumes a processor or dma master on avalon, same clock as the engine
`timescale 1ns/10ps
`include "pce_defines.svh"
module pce_host
	import pce_pkg::*;
#(
	parameter int DATA_W = 32
)
(
	input wire logic i_mclk,
	input wire logic i_reset,
	pce_if.host lnk,
	input wire logic [1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic o_dma_req
);
	localparam int ENT_W = DATA_W + 2;
	logic [ENT_W-1:0] buf_q [2];
	logic [ENT_W-1:0] buf_d [2];
	logic wp_q;
	logic wp_d;
	logic rp_q;
	logic rp_d;
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	logic cfg_q;
	logic cfg_d;
	pce_sel_t sel_q;
	pce_sel_t sel_d;
	logic [31:0] cw_q;
	logic [31:0] cw_d;
	logic rdone_q;
	logic rdone_d;
	logic [31:0] rdat_q;
	logic [31:0] rdat_d;
	logic is_data;
	logic full;
	logic empty;
	logic cfg_ok;
	logic push;
	logic pop;
	pce_size_t wsz;

	assign is_data = (i_avs_address == `PCE_ADDR_DATA);
	assign full = cnt_q[1];
	assign empty = (cnt_q == 2'h0);
	// config waits for a drained buffer and an idle engine so it lands between words
	// words held while disabled must not block the write that enables the engine
	assign cfg_ok = (empty | ~lnk.ctrl_rd[`PCE_CTRL_EN]) & ~lnk.busy & ~cfg_q;
	assign push = i_avs_write & is_data & ~full;
	assign pop = lnk.dat_valid & lnk.dat_ready;

	always_comb
	begin
		case (i_avs_byteenable)
			`PCE_BE_BYTE: wsz = PCE_SZ_8;
			`PCE_BE_HALF: wsz = PCE_SZ_16;
			default: wsz = PCE_SZ_32;
		endcase
	end

	always_comb
	begin
		if (i_avs_read)
		begin
			o_avs_waitrequest = ~rdone_q;
		end
		else if (i_avs_write && is_data)
		begin
			o_avs_waitrequest = full;
		end
		else if (i_avs_write)
		begin
			o_avs_waitrequest = ~cfg_ok;
		end
		else
		begin
			o_avs_waitrequest = 1'b0;
		end
	end

	always_comb
	begin
		buf_d = buf_q;
		wp_d = wp_q;
		rp_d = rp_q;
		cnt_d = cnt_q;
		if (push)
		begin
			buf_d[wp_q] = {wsz, i_avs_writedata[DATA_W-1:0]};
			wp_d = ~wp_q;
		end
		if (pop)
		begin
			rp_d = ~rp_q;
		end
		cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			buf_q[0] <= '0;
			buf_q[1] <= '0;
			wp_q <= 1'b0;
			rp_q <= 1'b0;
			cnt_q <= 2'h0;
		end
		else
		begin
			buf_q <= buf_d;
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
		end
	end

	// polynomial and seed are forwarded untouched: software owns their justification
	always_comb
	begin
		cfg_d = i_avs_write & ~is_data & cfg_ok;
		sel_d = sel_q;
		cw_d = cw_q;
		if (cfg_d)
		begin
			case (i_avs_address)
				`PCE_ADDR_POLY: sel_d = PCE_SEL_POLY;
				`PCE_ADDR_VAL: sel_d = PCE_SEL_VAL;
				default: sel_d = PCE_SEL_CTRL;
			endcase
			cw_d = i_avs_writedata;
		end
		rdone_d = i_avs_read & ~rdone_q;
		rdat_d = rdat_q;
		if (i_avs_read && !rdone_q)
		begin
			case (i_avs_address)
				`PCE_ADDR_CTRL:
				begin
					rdat_d = 32'h00000000;
					rdat_d[`PCE_CTRL_W-1:0] = lnk.ctrl_rd;
					rdat_d[`PCE_STAT_BUSY] = lnk.busy | ~empty | cfg_q;
				end
				`PCE_ADDR_POLY: rdat_d = lnk.poly_rd;
				`PCE_ADDR_VAL: rdat_d = lnk.val_rd;
				default: rdat_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			cfg_q <= 1'b0;
			sel_q <= PCE_SEL_CTRL;
			cw_q <= 32'h00000000;
			rdone_q <= 1'b0;
			rdat_q <= 32'h00000000;
		end
		else
		begin
			cfg_q <= cfg_d;
			sel_q <= sel_d;
			cw_q <= cw_d;
			rdone_q <= rdone_d;
			rdat_q <= rdat_d;
		end
	end

	// words wait here until the engine is enabled and idle; length is the writer's business
	assign lnk.dat_valid = ~empty;
	assign lnk.dat_size = pce_size_t'(buf_q[rp_q][ENT_W-1:DATA_W]);
	assign lnk.dat_word = 32'(buf_q[rp_q][DATA_W-1:0]);
	assign lnk.cfg_wr = cfg_q;
	assign lnk.cfg_sel = sel_q;
	assign lnk.cfg_wdata = cw_q;
	assign o_avs_readdata = rdat_q;
	assign o_dma_req = lnk.dma_req & ~full;
endmodule : pce_host

// *** pce_link_assertions.sv ***
// checker of the crc link: busy length, config updates, dma request
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/10ps
`include "pce_defines.svh"
module pce_link_assertions
	import pce_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic cfg_wr,
	input wire pce_sel_t cfg_sel,
	input wire logic [31:0] cfg_wdata,
	input wire logic dat_valid,
	input wire logic dat_ready,
	input wire pce_size_t dat_size,
	input wire logic [31:0] dat_word,
	input wire logic busy,
	input wire logic dma_req,
	input wire logic [`PCE_CTRL_W-1:0] ctrl_rd,
	input wire logic [31:0] poly_rd,
	input wire logic [31:0] val_rd
);
	logic take;
	logic [5:0] len_q, len_d, cnt_q, cnt_d;
	assign take = dat_valid && dat_ready;
	// count restarts at each take so back-to-back words cannot merge
	always_comb
	begin
		len_d = len_q;
		cnt_d = busy ? cnt_q + 6'h01 : cnt_q;
		if (take)
		begin
			len_d = (dat_size == PCE_SZ_8) ? `PCE_BITS_BYTE :
				(dat_size == PCE_SZ_16) ? `PCE_BITS_HALF : `PCE_BITS_WORD;
			cnt_d = 6'h00;
		end
	end
	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			len_q <= 6'h00;
			cnt_q <= 6'h00;
		end
		else
		begin
			len_q <= len_d;
			cnt_q <= cnt_d;
		end
	end
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	AST_BUSY_LEN: assert property ($fell(busy) |-> cnt_q == len_q)
		else $error("busy length differs from word width");
	AST_BYTE_LEN: assert property (
		take && dat_size == PCE_SZ_8 |=> busy[*8] ##1 !busy)
		else $error("byte word not eight busy cycles");
	AST_BUSY_CAUSE: assert property ($rose(busy) |-> $past(take))
		else $error("busy rose without a taken word");
	AST_READY_EN: assert property (
		dat_ready |-> ctrl_rd[`PCE_CTRL_EN] && !busy)
		else $error("ready while disabled or busy");
	AST_POLY_CFG: assert property (
		cfg_wr && cfg_sel == PCE_SEL_POLY |=> poly_rd == $past(cfg_wdata))
		else $error("polynomial not stored as written");
	AST_CTRL_CFG: assert property (
		cfg_wr && cfg_sel == PCE_SEL_CTRL |=> ctrl_rd == $past(cfg_wdata[`PCE_CTRL_W-1:0]))
		else $error("control not stored as written");
	AST_VAL_RAW: assert property (
		cfg_wr && cfg_sel == PCE_SEL_VAL && !ctrl_rd[`PCE_CTRL_MSB] && !ctrl_rd[`PCE_CTRL_SWOUT]
		|=> val_rd == $past(cfg_wdata))
		else $error("raw value view differs");
	AST_CFG_IDLE: assert property (cfg_wr |-> !busy)
		else $error("config applied while busy");
	AST_DMA_EN: assert property (
		dma_req |-> ctrl_rd[`PCE_CTRL_EN] && ctrl_rd[`PCE_CTRL_DMA] && !busy)
		else $error("dma request without both enables or while busy");
	AST_DMA_REQ: assert property (
		ctrl_rd[`PCE_CTRL_EN] && ctrl_rd[`PCE_CTRL_DMA] && !busy && !take && !cfg_wr |=> dma_req)
		else $error("no dma request while enabled and idle");
endmodule : pce_link_assertions

// *** tb.sv ***
// testbench: host and engine joined by pce_if, avalon master, crc model
// assumes 40 MHz clock; results are compared as they appear
`timescale 1ns/10ps
`include "pce_defines.svh"
module tb;
	import pce_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] av_a = 2'h0;
	logic av_rd = 1'b0;
	logic av_wr = 1'b0;
	logic [31:0] av_wd = 32'h00000000;
	logic [3:0] av_be = 4'hF;
	logic [31:0] rdata, e_crc, crc_m, poly_m;
	logic wreq, dreq, e_busy;
	logic [4:0] ctl_m;
	logic [31:0] exp_q[$];
	int bad_count = 0;
	int n_compared = 0;
	int cyc = 0;
	pce_if lnk();
	pce_host i_pce_host(.i_mclk(mclk), .i_reset(rst), .lnk(lnk), .i_avs_address(av_a),
		.i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wd),
		.i_avs_byteenable(av_be), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
		.o_dma_req(dreq));
	pce_engine i_pce_engine(.i_mclk(mclk), .i_reset(rst), .lnk(lnk), .o_busy(e_busy),
		.o_crc_value(e_crc));
	pce_link_assertions i_pce_link_assertions(.i_mclk(mclk), .i_reset(rst),
		.cfg_wr(lnk.cfg_wr), .cfg_sel(lnk.cfg_sel), .cfg_wdata(lnk.cfg_wdata),
		.dat_valid(lnk.dat_valid), .dat_ready(lnk.dat_ready), .dat_size(lnk.dat_size),
		.dat_word(lnk.dat_word), .busy(lnk.busy), .dma_req(lnk.dma_req),
		.ctrl_rd(lnk.ctrl_rd), .poly_rd(lnk.poly_rd), .val_rd(lnk.val_rd));
	always #12.5 mclk = ~mclk;
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task print_verdict;
		if (bad_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict
	always @(posedge mclk)
	begin
		cyc++;
		if (av_rd && wreq === 1'b0)
			cmp(rdata, exp_q.pop_front());
		if (cyc == 20000)
		begin
			bad_count++;
			print_verdict();
		end
	end
	task bus(input logic [1:0] a, input logic w, input logic [31:0] d, input logic [3:0] be);
		@(posedge mclk);
		av_a <= a;
		av_rd <= !w;
		av_wr <= w;
		av_wd <= d;
		av_be <= be;
		do
			@(posedge mclk);
		while (wreq !== 1'b0);
		av_rd <= 1'b0;
		av_wr <= 1'b0;
	endtask : bus
	task rd(input logic [1:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(a, 1'b0, 32'h00000000, 4'hF);
	endtask : rd
	function automatic logic [31:0] view(input logic [31:0] c);
		logic [31:0] r;
		r = ctl_m[`PCE_CTRL_MSB] ? {<<{c}} : c;
		return ctl_m[`PCE_CTRL_SWOUT] ? {<<8{r}} : r;
	endfunction : view
	task wdat(input int nb);
		logic [31:0] d;
		logic [7:0] b;
		logic fb;
		d = $urandom();
		for (int i = 0; i < nb; i++)
		begin
			b = ctl_m[`PCE_CTRL_SWIN] ? d[8*(nb-1-i) +: 8] : d[8*i +: 8];
			for (int k = 0; k < 8; k++)
			begin
				fb = ctl_m[`PCE_CTRL_MSB] ? crc_m[31] ^ b[7-k] : crc_m[0] ^ b[k];
				crc_m = ctl_m[`PCE_CTRL_MSB] ? crc_m << 1 : crc_m >> 1;
				if (fb)
					crc_m = crc_m ^ poly_m;
			end
		end
		bus(`PCE_ADDR_DATA, 1'b1, d, nb == 1 ? 4'h1 : nb == 2 ? 4'h3 : 4'hF);
	endtask : wdat
	task fin;
		@(posedge mclk);
		while (lnk.busy !== 1'b0 || lnk.dat_valid !== 1'b0)
			@(posedge mclk);
		@(posedge mclk);
		cmp({31'h00000000, e_busy}, 32'h00000000);
		cmp(e_crc, view(crc_m));
		rd(`PCE_ADDR_VAL, view(crc_m));
		rd(`PCE_ADDR_CTRL, {27'h0000000, ctl_m});
	endtask : fin
	initial
	begin
		void'($urandom(32'hD4513146));
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		rd(`PCE_ADDR_POLY, `PCE_POLY_RESET);
		rd(`PCE_ADDR_VAL, `PCE_VAL_RESET);
		rd(`PCE_ADDR_CTRL, 32'h00000000);
		rd(`PCE_ADDR_DATA, 32'h00000000);
		poly_m = `PCE_POLY_RESET;
		crc_m = `PCE_VAL_RESET;
		ctl_m = 5'h01;
		bus(`PCE_ADDR_CTRL, 1'b1, 32'h00000001, 4'hF);
		wdat(4);
		// word taken one edge after the push, busy high from that same edge
		repeat (2) @(posedge mclk);
		cmp({31'h00000000, e_busy}, 32'h00000001);
		rd(`PCE_ADDR_CTRL, 32'h00010001);
		fin;
		// every format combination; the writes outrun the engine to fill the buffer
		for (int m = 0; m < 8; m++)
		begin
			ctl_m = {m[2:0], 2'b00};
			bus(`PCE_ADDR_CTRL, 1'b1, {27'h0000000, ctl_m}, 4'hF);
			poly_m = $urandom() | {31'h00000000, ctl_m[`PCE_CTRL_MSB]};
			crc_m = $urandom();
			bus(`PCE_ADDR_POLY, 1'b1, poly_m, 4'hF);
			bus(`PCE_ADDR_VAL, 1'b1, crc_m, 4'hF);
			rd(`PCE_ADDR_POLY, poly_m);
			rd(`PCE_ADDR_VAL, view(crc_m));
			ctl_m[`PCE_CTRL_EN] = 1'b1;
			bus(`PCE_ADDR_CTRL, 1'b1, {27'h0000000, ctl_m}, 4'hF);
			for (int j = 0; j < 4; j++)
			begin
				wdat(1);
				wdat(2);
				wdat(4);
			end
			fin;
		end
		ctl_m = 5'h03;
		bus(`PCE_ADDR_CTRL, 1'b1, 32'h00000003, 4'hF);
		repeat (3) @(posedge mclk);
		cmp({31'h00000000, dreq}, 32'h00000001);
		wdat(4);
		repeat (2) @(posedge mclk);
		cmp({31'h00000000, dreq}, 32'h00000000);
		fin;
		ctl_m = 5'h01;
		bus(`PCE_ADDR_CTRL, 1'b1, 32'h00000001, 4'hF);
		repeat (3) @(posedge mclk);
		cmp({31'h00000000, dreq}, 32'h00000000);
		print_verdict();
	end
endmodule : tb
